// >>> design/wis_section_overhead_consts.svh
// Constants for section-overhead insertion and extraction.
// Summary of operation
// - Default transmit trace is sixteen stored octets.
// - Inactive trace sends 0x89 header plus zeros.
// - Capture repeating receive trace, no boundary search.
// - Single, 16 or 64 octets, per direction.
// - 64-octet mode uses base plus extended sets.
// - Receive store refreshed once per frame.
// - Growth octet programmable, resets to 0xCC.
// - Scramble all but row one when enabled.
// - Descrambler on after reset, bypass when cleared.
// - Parity over scrambled frame into next B1.
// - Receive parity mismatches add to wrapping counter.
// - Tick copies counter to snapshot, clears it.
// - Nonzero count: pending, live, two masked interrupts.
// - Block mode adds one per errored frame.
// - Orderwire octet programmable, resets to zero.
// - User channel octet programmable, resets to zero.
// - Three data channel octets, reset to zero.
// - Reserved and unused octets sent as zero.
// - Programmable first and second pointer octets.
// - Programmable pointer action octet.
// - Programmed octets repeat every frame unchanged.
`ifndef WIS_SECTION_OVERHEAD_CONSTS_SVH
`define WIS_SECTION_OVERHEAD_CONSTS_SVH
`define OFS_CTRL 8'h00
`define OFS_OH1 8'h04
`define OFS_OH2 8'h08
`define OFS_OH3 8'h0C
`define OFS_STAT 8'h10
`define OFS_MASK 8'h14
`define OFS_SNAP_LO 8'h18
`define OFS_SNAP_HI 8'h1C
`define OFS_TX_TRACE 8'h40
`define OFS_RX_TRACE 8'h80
`define CTRL_RESET 32'h0000_0003
`define OH1_RESET 32'h0000_00CC
`define OH2_RESET 32'h0000_0000
`define OH3_RESET 32'h0000_0000
`define TRACE_HEADER 8'h89
`define SCR_SEED 7'h7F
`define FRAME_TIME_US 125
`define FRAME_CYCLES (`FRAME_TIME_US * 25)
`endif

// >>> design/wis_section_overhead_pkg.sv
// Types shared by the section-overhead block.
package wis_section_overhead_pkg;
	typedef enum logic [3:0] {
		OH_PASS = 4'h0, OH_J0 = 4'h1, OH_Z0 = 4'h2, OH_B1 = 4'h3,
		OH_E1 = 4'h4, OH_F1 = 4'h5, OH_D1 = 4'h6, OH_D2 = 4'h7,
		OH_D3 = 4'h8, OH_H1 = 4'h9, OH_H2 = 4'hA, OH_H3 = 4'hB,
		OH_ZERO = 4'hC
	} oh_sel_type;
	typedef enum logic [1:0] {
		LEN_16 = 2'h0, LEN_1 = 2'h1, LEN_64 = 2'h2, LEN_DEFAULT = 2'h3
	} trace_len_type;
endpackage : wis_section_overhead_pkg

// >>> design/wis_section_overhead.sv
// Section-overhead insertion, scrambling, parity and trace handling.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "wis_section_overhead_consts.svh"
module wis_section_overhead (
	input wire logic clk, // 25 MHz clock
	input wire logic rst_n, // Synchronous reset
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic perf_monitor_tick, // Monitoring tick pin
	input wire logic [7:0] tx_data_in, // Transmit byte in
	input wire logic tx_sof, // First byte of frame
	input wire logic tx_row1, // Byte lies in overhead row one
	input wire wis_section_overhead_pkg::oh_sel_type tx_oh_sel, // Octet slot
	output logic [7:0] tx_data_out, // Transmit byte out
	output logic tx_sof_out, // Frame start out
	input wire logic [7:0] rx_data_in, // Receive byte in
	input wire logic rx_sof, // First byte of frame
	input wire logic rx_row1, // Byte lies in overhead row one
	input wire wis_section_overhead_pkg::oh_sel_type rx_oh_sel, // Octet slot
	output logic [7:0] rx_data_out, // Descrambled byte out
	output logic irq_out_a, // Interrupt A
	output logic irq_out_b // Interrupt B
);
	import wis_section_overhead_pkg::*;

	function automatic logic [14:0] scr_step(input logic [6:0] s);
		logic [6:0] st;
		logic [7:0] key;
		st = s;
		key = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			key[i] = st[6];
			st = {st[5:0], st[6] ^ st[5]};
		end
		return {key, st};
	endfunction : scr_step

	function automatic logic [3:0] popcount(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++)
			n = n + {3'h0, v[i]};
		return n;
	endfunction : popcount

	function automatic logic [5:0] trace_next(input logic [5:0] i, input trace_len_type l);
		case (l)
			LEN_1: return 6'h00;
			LEN_64: return i + 6'h01;
			default: return {2'h0, i[3:0] + 4'h1};
		endcase
	endfunction : trace_next

	logic [31:0] ctrl_reg, oh1_reg, oh2_reg, oh3_reg;
	logic [1:0] mask_reg;
	logic [7:0] tx_trace_mem [0:63];
	logic [7:0] rx_trace_mem [0:63];
	logic [31:0] section_parity_err_counter;
	logic [31:0] snap_reg;
	logic parity_nonzero_pending, parity_nonzero_live;
	logic tick_s1_reg, tick_s2_reg, tick_s3_reg, tick_edge;
	logic [6:0] tx_scr_reg, rx_scr_reg;
	logic [7:0] tx_bip_reg, tx_b1_reg, rx_bip_reg, rx_b1_reg;
	logic [5:0] tx_idx_reg, rx_idx_reg;
	logic [7:0] tx_pre, tx_next, rx_next, rx_err_bits;
	logic [14:0] tx_step, rx_step;
	logic [31:0] rx_inc;
	logic tx_scr_enable, rx_descramble_enable, parity_block_count_mode;
	trace_len_type tx_trace_length_sel, rx_trace_length_sel;
	logic apb_acc, apb_done, apb_wr, apb_rd, stat_read, addr_ok;
	logic [31:0] rd_word;

	assign tx_scr_enable = ctrl_reg[0];
	assign rx_descramble_enable = ctrl_reg[1];
	assign parity_block_count_mode = ctrl_reg[2];
	assign tx_trace_length_sel = trace_len_type'(ctrl_reg[5:4]);
	assign rx_trace_length_sel = trace_len_type'(ctrl_reg[7:6]);

	// APB: one wait state, so every answer comes from a flip-flop.
	// Writes and the status clear land only at the edge that completes the access.
	assign apb_acc = psel && penable && !pready;
	assign apb_done = psel && penable && pready;
	assign apb_wr = apb_done && pwrite;
	assign apb_rd = apb_acc && !pwrite;
	assign stat_read = apb_done && !pwrite && paddr == `OFS_STAT;

	always_comb
	begin
		addr_ok = 1'b1;
		rd_word = 32'h0000_0000;
		if (paddr[7:6] == 2'h1 || paddr[7:6] == 2'h2)
		begin
			for (int b = 0; b < 4; b++)
				rd_word[8*b +: 8] = paddr[7] ? rx_trace_mem[{paddr[5:2], 2'(b)}]
					: tx_trace_mem[{paddr[5:2], 2'(b)}];
			addr_ok = paddr[1:0] == 2'h0;
		end
		else
			case (paddr)
				`OFS_CTRL: rd_word = ctrl_reg;
				`OFS_OH1: rd_word = oh1_reg;
				`OFS_OH2: rd_word = oh2_reg;
				`OFS_OH3: rd_word = oh3_reg;
				`OFS_STAT: rd_word = {30'h0, parity_nonzero_live, parity_nonzero_pending};
				`OFS_MASK: rd_word = {30'h0, mask_reg};
				`OFS_SNAP_LO: rd_word = {16'h0, snap_reg[15:0]};
				`OFS_SNAP_HI: rd_word = {16'h0, snap_reg[31:16]};
				default: addr_ok = 1'b0;
			endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= apb_acc;
			pslverr <= apb_acc && !addr_ok;
			prdata <= (apb_rd && addr_ok) ? rd_word : 32'h0000_0000;
		end
	end

	// Programmed octets stay static until rewritten.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_reg <= `CTRL_RESET;
			oh1_reg <= `OH1_RESET;
			oh2_reg <= `OH2_RESET;
			oh3_reg <= `OH3_RESET;
			mask_reg <= 2'h0;
		end
		else if (apb_wr)
			case (paddr)
				`OFS_CTRL: ctrl_reg <= {24'h0, pwdata[7:4], 1'b0, pwdata[2:0]};
				`OFS_OH1: oh1_reg <= pwdata;
				`OFS_OH2: oh2_reg <= pwdata;
				`OFS_OH3: oh3_reg <= {24'h0, pwdata[7:0]};
				`OFS_MASK: mask_reg <= pwdata[1:0];
				default: ;
			endcase
	end

	// Trace store has no reset; software loads the header itself.
	always_ff @(posedge clk)
	begin
		if (apb_wr && paddr[7:6] == 2'h1 && paddr[1:0] == 2'h0)
			for (int b = 0; b < 4; b++)
				tx_trace_mem[{paddr[5:2], 2'(b)}] <= pwdata[8*b +: 8];
	end

	always_comb
	begin
		case (tx_oh_sel)
			OH_J0:
				if (tx_trace_length_sel == LEN_DEFAULT)
					tx_pre = tx_idx_reg == 6'h00 ? `TRACE_HEADER : 8'h00;
				else
					tx_pre = tx_trace_mem[tx_idx_reg];
			OH_Z0: tx_pre = oh1_reg[7:0];
			OH_B1: tx_pre = tx_b1_reg;
			OH_E1: tx_pre = oh1_reg[15:8];
			OH_F1: tx_pre = oh1_reg[23:16];
			OH_D1: tx_pre = oh1_reg[31:24];
			OH_D2: tx_pre = oh2_reg[7:0];
			OH_D3: tx_pre = oh2_reg[15:8];
			OH_H1: tx_pre = oh2_reg[23:16];
			OH_H2: tx_pre = oh2_reg[31:24];
			OH_H3: tx_pre = oh3_reg[7:0];
			OH_ZERO: tx_pre = 8'h00;
			default: tx_pre = tx_data_in;
		endcase
		tx_step = scr_step(tx_scr_reg);
		tx_next = tx_pre ^ ((tx_scr_enable && !tx_row1) ? tx_step[14:7] : 8'h00);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_data_out <= 8'h00;
			tx_sof_out <= 1'b0;
			tx_scr_reg <= `SCR_SEED;
		end
		else
		begin
			tx_data_out <= tx_next;
			tx_sof_out <= tx_sof;
			tx_scr_reg <= tx_row1 ? `SCR_SEED : tx_step[6:0];
		end
	end

	// Parity runs on the scrambled byte; the total feeds B1 of the next frame.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx_bip_reg <= 8'h00;
			tx_b1_reg <= 8'h00;
			tx_idx_reg <= 6'h00;
		end
		else
		begin
			tx_bip_reg <= tx_sof ? tx_next : tx_bip_reg ^ tx_next;
			if (tx_sof)
				tx_b1_reg <= tx_bip_reg;
			if (tx_oh_sel == OH_J0)
				tx_idx_reg <= trace_next(tx_idx_reg, tx_trace_length_sel);
		end
	end

	always_comb
	begin
		rx_step = scr_step(rx_scr_reg);
		rx_next = rx_data_in ^ ((rx_descramble_enable && !rx_row1) ? rx_step[14:7] : 8'h00);
		rx_err_bits = rx_next ^ rx_b1_reg;
		if (parity_block_count_mode)
			rx_inc = {31'h0, rx_err_bits != 8'h00};
		else
			rx_inc = {28'h0, popcount(rx_err_bits)};
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rx_data_out <= 8'h00;
			rx_scr_reg <= `SCR_SEED;
			rx_bip_reg <= 8'h00;
			rx_b1_reg <= 8'h00;
			rx_idx_reg <= 6'h00;
		end
		else
		begin
			rx_data_out <= rx_next;
			rx_scr_reg <= rx_row1 ? `SCR_SEED : rx_step[6:0];
			rx_bip_reg <= rx_sof ? rx_data_in : rx_bip_reg ^ rx_data_in;
			if (rx_sof)
				rx_b1_reg <= rx_bip_reg;
			if (rx_oh_sel == OH_J0)
				rx_idx_reg <= trace_next(rx_idx_reg, rx_trace_length_sel);
		end
	end

	// No boundary search: after realignment the stored message may look rotated.
	always_ff @(posedge clk)
	begin
		if (rx_oh_sel == OH_J0)
			rx_trace_mem[rx_idx_reg] <= rx_data_in;
	end

	// The tick pin is synchronised, then edge detected past the second stage.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tick_s1_reg <= 1'b0;
			tick_s2_reg <= 1'b0;
			tick_s3_reg <= 1'b0;
		end
		else
		begin
			tick_s1_reg <= perf_monitor_tick;
			tick_s2_reg <= tick_s1_reg;
			tick_s3_reg <= tick_s2_reg;
		end
	end
	assign tick_edge = tick_s2_reg && !tick_s3_reg;

	// An error in the tick cycle seeds the cleared counter, so none is lost.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			section_parity_err_counter <= 32'h0000_0000;
			snap_reg <= 32'h0000_0000;
		end
		else
		begin
			if (tick_edge)
			begin
				snap_reg <= section_parity_err_counter;
				section_parity_err_counter <= (rx_oh_sel == OH_B1) ? rx_inc : 32'h0000_0000;
			end
			else if (rx_oh_sel == OH_B1)
				section_parity_err_counter <= section_parity_err_counter + rx_inc;
		end
	end

	// The pending flag is set by the tick and cleared by a status read; set wins.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			parity_nonzero_pending <= 1'b0;
			parity_nonzero_live <= 1'b0;
			irq_out_a <= 1'b0;
			irq_out_b <= 1'b0;
		end
		else
		begin
			if (tick_edge && section_parity_err_counter != 32'h0000_0000)
				parity_nonzero_pending <= 1'b1;
			else if (stat_read)
				parity_nonzero_pending <= 1'b0;
			parity_nonzero_live <= snap_reg != 32'h0000_0000;
			irq_out_a <= parity_nonzero_pending && mask_reg[0];
			irq_out_b <= parity_nonzero_pending && mask_reg[1];
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence tick_seen_s;
		tick_edge ##0 section_parity_err_counter != 32'h0000_0000;
	endsequence

	trace_default_a: assert property (
		tx_oh_sel == OH_J0 && tx_trace_length_sel == LEN_DEFAULT && tx_idx_reg == 6'h00
		&& tx_row1 |=> tx_data_out == `TRACE_HEADER)
		else $error("default trace header not sent");
	growth_octet_a: assert property (
		tx_oh_sel == OH_Z0 && tx_row1 |=> tx_data_out == $past(oh1_reg[7:0]))
		else $error("growth octet value wrong");
	row_one_clear_a: assert property (
		tx_row1 && tx_oh_sel == OH_PASS |=> tx_data_out == $past(tx_data_in))
		else $error("row one byte was scrambled");
	scramble_off_a: assert property (
		!tx_scr_enable && tx_oh_sel == OH_PASS |=> tx_data_out == $past(tx_data_in))
		else $error("byte scrambled while disabled");
	descramble_off_a: assert property (
		!rx_descramble_enable |=> rx_data_out == $past(rx_data_in))
		else $error("descrambler not bypassed");
	reserved_zero_a: assert property (
		tx_oh_sel == OH_ZERO && (tx_row1 || !tx_scr_enable) |=> tx_data_out == 8'h00)
		else $error("reserved octet not zero");
	snapshot_tick_a: assert property (
		tick_edge |=> snap_reg == $past(section_parity_err_counter))
		else $error("snapshot not taken on tick");
	block_mode_a: assert property (
		parity_block_count_mode && !tick_edge && rx_oh_sel == OH_B1
		|=> section_parity_err_counter - $past(section_parity_err_counter) <= 32'h1)
		else $error("block mode added more than one");
	pending_irq_a: assert property (
		tick_seen_s ##1 mask_reg[0] |=> irq_out_a)
		else $error("pending not routed to interrupt A");
	pending_hold_a: assert property (
		parity_nonzero_pending && !stat_read |=> parity_nonzero_pending)
		else $error("pending flag dropped without read");
endmodule : wis_section_overhead

// >>> sim/line_far_end.sv
// Behavioural far-end line framer that feeds the receive side.
`timescale 1ns/1ps
module line_far_end (
	input wire logic clk, // Frame clock
	input wire logic rst_n, // Synchronous reset
	input wire logic [7:0] b1_flip, // Bits inverted in the sent B1
	output logic [7:0] rx_data, // Line byte
	output logic rx_sof, // Frame start
	output logic rx_row1, // Row one byte
	output logic [7:0] plain, // Byte before scrambling
	output wis_section_overhead_pkg::oh_sel_type rx_sel // Slot code
);
	import wis_section_overhead_pkg::*;
	logic [6:0] s;
	logic [7:0] acc, par, v;
	int b, fr;
	// Short 32-byte frames keep runs brief; only the trace octet sits in row one.
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			b = 0;
			fr = 0;
			acc = 8'h00;
			rx_data <= 8'h00;
			rx_sof <= 1'b0;
			rx_row1 <= 1'b0;
			plain <= 8'h00;
			rx_sel <= OH_PASS;
		end
		else
		begin
			if (b == 0)
			begin
				par = acc;
				acc = 8'h00;
				s = 7'h7F;
			end
			v = b == 0 ? 8'(fr) : (b == 1 && fr > 0) ? par ^ b1_flip : 8'(fr * 7 + b);
			plain <= v;
			if (b > 0)
				for (int i = 7; i >= 0; i--)
				begin
					v[i] ^= s[6];
					s = {s[5:0], s[6] ^ s[5]};
				end
			acc ^= v;
			rx_data <= v;
			rx_sof <= b == 0;
			rx_row1 <= b == 0;
			rx_sel <= b == 0 ? OH_J0 : (b == 1 && fr > 0) ? OH_B1 : OH_PASS;
			b = (b + 1) % 32;
			if (b == 0)
				fr++;
		end
	end
endmodule : line_far_end

// >>> sim/wis_section_overhead_tb.sv
// Self-checking bench for the section-overhead block.
`timescale 1ns/1ps
`include "wis_section_overhead_consts.svh"
`define CHK(n, e, s) begin checks_done++; if ((e) !== (s)) begin miscompares++; \
	$display("MISMATCH %s expected %0h seen %0h", n, e, s); end end
module wis_section_overhead_tb;
	import wis_section_overhead_pkg::*;
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, perf_monitor_tick, tx_sof;
	logic tx_row1, rx_sof, rx_row1, irq_out_a, irq_out_b, txv, txv_d, first;
	logic tx_sof_o, rxv, dsc;
	logic [7:0] paddr, tx_data_in, tx_data_out, rx_data_in, flip, acc, par;
	logic [7:0] rxo, plain, rexp;
	logic [7:0] tr[64];
	logic [31:0] pwdata, prdata, ctrl, oh1, oh2, oh3, r;
	logic [32:0] ex;
	logic [32:0] rdq[$];
	logic [8:0] txq[$];
	logic [6:0] s;
	logic [15:0] hp[4];
	oh_sel_type tx_oh_sel, rx_oh_sel;
	int miscompares, checks_done, seed, tidx;
	wis_section_overhead dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .perf_monitor_tick, .tx_data_in, .tx_sof, .tx_row1,
		.tx_oh_sel, .tx_data_out, .tx_sof_out(tx_sof_o), .rx_data_in, .rx_sof, .rx_row1,
		.rx_oh_sel, .rx_data_out(rxo), .irq_out_a, .irq_out_b);
	line_far_end far (.clk, .rst_n, .b1_flip(flip), .rx_data(rx_data_in), .rx_sof,
		.rx_row1, .plain, .rx_sel(rx_oh_sel));
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		txv_d <= txv;
		rxv <= rxv | rx_sof;
		// The bypass mode follows the control write at the edge that completes it.
		rexp <= dsc ? plain : rx_data_in;
		if (psel && penable && pready && pwrite && paddr == `OFS_CTRL)
			dsc <= pwdata[1];
		if (txv_d)
		begin
			ex = txq.pop_front();
			`CHK("tx byte", ex[8:0], {tx_sof_o, tx_data_out})
		end
		if (rxv)
			`CHK("rx byte", rexp, rxo)
		if (pready && !pwrite)
		begin
			ex = rdq.pop_front();
			`CHK("read word", ex, {pslverr, prdata})
		end
	end
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	task rd(input logic [7:0] a, input logic [32:0] e);
		rdq.push_back(e);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd
	task tx_scramble_enable(inout logic [7:0] v);
		for (int i = 7; i >= 0; i--)
		begin
			v[i] ^= s[6];
			s = {s[5:0], s[6] ^ s[5]};
		end
	endtask : tx_scramble_enable
	task automatic frames(input int n);
		logic [7:0] v, din, jv;
		logic [7:0] ov[13];
		oh_sel_type sl;
		for (int f = 0; f < n; f++)
		begin
			for (int b = 0; b < 16; b++)
			begin
				din = 8'($random(seed));
				sl = ((first && b == 2) || b > 11) ? OH_PASS : oh_sel_type'(b + 1);
				if (b == 0)
				begin
					par = acc;
					acc = 8'h00;
				end
				jv = ctrl[5:4] == 2'h3 ? (tidx == 0 ? `TRACE_HEADER : 8'h00) : tr[tidx];
				ov = '{din, jv, oh1[7:0], par, oh1[15:8], oh1[23:16], oh1[31:24], oh2[7:0],
					oh2[15:8], oh2[23:16], oh2[31:24], oh3[7:0], 8'h00};
				v = ov[sl];
				if (sl == OH_J0)
					tidx = ctrl[5:4] == 2'h1 ? 0 : (tidx + 1) % (ctrl[5:4] == 2'h2 ? 64 : 16);
				if (b < 2)
					s = `SCR_SEED;
				else if (ctrl[0])
					tx_scramble_enable(v);
				acc ^= v;
				txq.push_back({b == 0, v});
				tx_data_in <= din;
				tx_sof <= b == 0;
				tx_row1 <= b < 2;
				tx_oh_sel <= sl;
				txv <= 1'b1;
				@(posedge clk);
			end
			first = 1'b0;
		end
		tx_row1 <= 1'b1;
		tx_sof <= 1'b0;
		tx_oh_sel <= OH_PASS;
		tx_data_in <= 8'h00;
		txv <= 1'b0;
	endtask : frames
	// The far end samples the flip at its B1 byte, so exactly three frames carry errors.
	task errs(input logic [7:0] m, input logic [31:0] e);
		repeat (2) @(posedge clk iff rx_sof);
		flip <= m;
		repeat (3) @(posedge clk iff rx_sof);
		flip <= 8'h00;
		repeat (2) @(posedge clk iff rx_sof);
		repeat (8) @(posedge clk);
		perf_monitor_tick <= 1'b1;
		repeat (4) @(posedge clk);
		perf_monitor_tick <= 1'b0;
		repeat (4) @(posedge clk);
		rd(`OFS_SNAP_LO, {17'h0_0000, e[15:0]});
		rd(`OFS_SNAP_HI, {17'h0_0000, e[31:16]});
		$display("parity round done");
	endtask : errs
	// Frame f lands in slot f mod 16, so each slot holds the newest frame of its residue.
	task rxtr(input int w);
		int fc;
		logic [31:0] e;
		@(posedge clk iff rx_sof);
		fc = far.fr;
		for (int k = 0; k < 4; k++)
			e[8 * k +: 8] = 8'(fc - (fc - 4 * w - k) % 16);
		rd(8'(`OFS_RX_TRACE + 4 * w), {1'b0, e});
	endtask : rxtr
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out
	initial
	begin
		#800000;
		miscompares++;
		close_out;
	end
	initial
	begin
		seed = 71845;
		{rst_n, psel, penable, pwrite, perf_monitor_tick, tx_sof, txv, txv_d} = 8'h00;
		{paddr, pwdata, tx_data_in, flip, acc, s, tidx} = '0;
		tx_row1 = 1'b1;
		tx_oh_sel = OH_PASS;
		first = 1'b1;
		rxv = 1'b0;
		dsc = 1'b1;
		hp = '{16'h0A62, 16'hFF93, 16'h0A6A, 16'hFF9B};
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(`OFS_CTRL, 33'h0_0000_0003);
		rd(`OFS_OH1, 33'h0_0000_00CC);
		rd(`OFS_OH2, 33'h0_0000_0000);
		rd(`OFS_MASK, 33'h0_0000_0000);
		rd(8'h20, 33'h1_0000_0000);
		$display("register reset test done");
		ctrl = 32'h0000_0003;
		oh1 = $random(seed);
		oh3 = 32'h0000_00FF & $random(seed);
		apb(1'b1, `OFS_OH1, oh1);
		apb(1'b1, `OFS_OH3, oh3);
		for (int i = 0; i < 16; i++)
		begin
			r = $random(seed);
			if (i == 0)
				r[7:0] = `TRACE_HEADER;
			for (int k = 0; k < 4; k++)
				tr[4 * i + k] = r[8 * k +: 8];
			apb(1'b1, 8'(`OFS_TX_TRACE + 4 * i), r);
		end
		for (int p = 0; p < 4; p++)
		begin
			oh2 = {hp[p], r[15:0]};
			apb(1'b1, `OFS_OH2, oh2);
			frames(4);
		end
		ctrl = 32'h0000_0023;
		apb(1'b1, `OFS_CTRL, ctrl);
		frames(64);
		ctrl = 32'h0000_0012;
		apb(1'b1, `OFS_CTRL, ctrl);
		frames(2);
		ctrl = 32'h0000_0033;
		apb(1'b1, `OFS_CTRL, ctrl);
		frames(16);
		rd(`OFS_CTRL, {1'b0, ctrl});
		$display("transmit overhead test done");
		apb(1'b1, `OFS_MASK, 32'h0000_0003);
		errs(8'h05, 32'h0000_0006);
		`CHK("irq a", irq_out_a, 1'b1)
		`CHK("irq b", irq_out_b, 1'b1)
		rd(`OFS_STAT, 33'h0_0000_0003);
		repeat (2) @(posedge clk);
		`CHK("irq a", irq_out_a, 1'b0)
		rd(`OFS_STAT, 33'h0_0000_0002);
		apb(1'b1, `OFS_MASK, 32'h0000_0001);
		apb(1'b1, `OFS_CTRL, 32'h0000_0037);
		errs(8'h05, 32'h0000_0003);
		`CHK("irq a", irq_out_a, 1'b1)
		`CHK("irq b", irq_out_b, 1'b0)
		rxtr(0);
		rxtr(3);
		$display("receive trace test done");
		apb(1'b1, `OFS_CTRL, 32'h0000_0035);
		repeat (40) @(posedge clk);
		$display("descrambler bypass test done");
		close_out;
	end
endmodule : wis_section_overhead_tb
